/* File: bench/ccp_host_model.sv */
// configuration host model: config clock, byte port and open-drain completion wire
`default_nettype none
module ccp_host_model (
    input wire logic clk,
    input wire logic clock_o,
    input wire logic clock_oe,
    output logic clock_wire,
    output logic [7:0] data,
    output logic select_n,
    output logic read_write_n,
    input wire logic done_o,
    input wire logic done_oe,
    output logic done_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    logic host_clk = 1'b0;
    logic hold_low = 1'b0;

    // host clock
    // host clock stands low between bytes, the device pin wins only when it drives
    assign clock_wire = clock_oe ? clock_o : host_clk;
    // external low hold
    // open drain with pull-up: low if either party pulls it down
    assign done_wire = ((done_oe && !done_o) || hold_low) ? 1'b0 : 1'b1;

    initial begin
        data = 8'h00;
        select_n = 1'b1;
        read_write_n = 1'b1;
    end

    // sampled at rise
    // byte set up half a period before the rise and held until the fall
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        #1;
        data = b;
        select_n = 1'b0;
        read_write_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        host_clk = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        host_clk = 1'b0;
        select_n = 1'b1;
        read_write_n = 1'b1;
        // released bus shows the inverse so a stale sample is visible
        data = ~b;
    endtask

    task automatic hold_done(input logic v);
        hold_low = v;
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking testbench of the configuration control pin logic
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ccp_pkg::*;

    logic clk = 1'b0;
    logic reset_n, clock_o, clock_oe, clock_wire, select_n, rw_n, busy, prog_n;
    logic done_o, done_oe, done_wire, tck, tms, tdi, usel, tdo, mem_clear, user_mode;
    logic out_valid, rdy, opt_load, drive, persist, cfg_end, stall, mstr;
    logic [7:0] data, out_data, b;
    logic [2:0] rate;
    logic [31:0] uid, id_v;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    ccp_config_pins dut_u (.clk(clk), .reset_n(reset_n), .master_mode(mstr),
        .cfg_clock_pin_i(clock_wire), .cfg_clock_pin_o(clock_o), .cfg_clock_pin_oe(clock_oe),
        .cfg_data_byte(data), .cfg_select_n(select_n), .cfg_read_write_n(rw_n), .busy(busy),
        .program_request_n(prog_n), .completion_pin_i(done_wire), .completion_pin_o(done_o),
        .completion_pin_oe(done_oe), .jtag_tck(tck), .jtag_tms(tms), .jtag_tdi(tdi),
        .jtag_user_select(usel), .jtag_tdo(tdo), .mem_clear(mem_clear), .user_mode(user_mode),
        .cfg_byte_data(out_data), .cfg_byte_valid(out_valid), .cfg_byte_ready(rdy),
        .opt_load(opt_load), .osc_rate_option(rate), .completion_drive_option(drive),
        .persist_option(persist), .user_identification_option(uid), .cfg_end(cfg_end));

    ccp_host_model host_u (.clk(clk), .clock_o(clock_o), .clock_oe(clock_oe),
        .clock_wire(clock_wire), .data(data), .select_n(select_n), .read_write_n(rw_n),
        .done_o(done_o), .done_oe(done_oe), .done_wire(done_wire));

    // ****************************************
    // compare and closing tasks
    // ****************************************
    task automatic chk_flag(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // stimulus helpers
    // ****************************************
    // capture on the first tck rise with tms high, then shift out lsb first
    task automatic read_id(input logic sel, output logic [31:0] v);
        @(posedge clk);
        #1;
        tms = 1'b1;
        tdi = sel;
        usel = sel;
        for (int i = 0; i < 32; i++) begin
            repeat (4) @(posedge clk);
            #1;
            tck = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            tck = 1'b0;
            tms = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            v[i] = tdo;
        end
    endtask

    task automatic pulse_ctl(input logic opt, input logic fin);
        @(posedge clk);
        #1;
        opt_load = opt;
        cfg_end = fin;
        @(posedge clk);
        #1;
        opt_load = 1'b0;
        cfg_end = 1'b0;
    endtask

    task automatic prog_pulse(input int n);
        @(posedge clk);
        #1;
        prog_n = 1'b0;
        repeat (n) @(posedge clk);
        #1;
        prog_n = 1'b1;
    endtask

    // bounded waits on design completion signals
    task automatic wait_load();
        for (int k = 0; k < 60 && mem_clear !== 1'b0; k++) @(posedge clk);
        #1;
    endtask

    task automatic wait_user();
        for (int k = 0; k < 60 && user_mode !== 1'b1; k++) @(posedge clk);
        #1;
    endtask

    task automatic drain();
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
        #1;
    endtask

    task automatic send_exp(input logic [7:0] v);
        exp_q.push_back(v);
        host_u.send_byte(v);
    endtask

    // ****************************************
    // receiver, monitor and watchdog
    // ****************************************
    // random stalls on the receiving side, forced off-ready by the stall flag
    always @(posedge clk) begin
        #1;
        rdy = stall ? 1'b0 : 1'($urandom % 2);
    end

    // sampled mid-cycle: a transfer happens at the next rising edge
    always @(negedge clk) begin
        if (out_valid === 1'b1 && rdy === 1'b1) begin
            chk_flag("byte was expected", 1'b1, exp_q.size() != 0);
            if (exp_q.size() != 0) begin
                chk_byte("byte stream", exp_q.pop_front(), out_data);
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(90));
        {reset_n, tck, tms, tdi, usel, opt_load, drive, persist, cfg_end} = '0;
        {rdy, stall, mstr, rate, uid, b, id_v} = '0;
        prog_n = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk_flag("clear in reset", 1'b1, mem_clear);
        chk_flag("completion oe in reset", 1'b1, done_oe);
        chk_flag("completion low in reset", 1'b0, done_o);
        chk_flag("clock oe in slave", 1'b0, clock_oe);
        reset_n = 1'b1;
        wait_load();
        chk_flag("load after power-up", 1'b0, mem_clear);
        read_id(1'b0, id_v);
        chk_word("device id while loading", DEVICE_ID_VALUE, id_v);
        for (int i = 0; i < 4; i++) send_exp(8'($urandom));
        drain();
        stall = 1'b1;
        send_exp(8'($urandom));
        send_exp(8'($urandom));
        host_u.send_byte(8'($urandom));
        chk_flag("busy on full buffer", 1'b1, busy);
        stall = 1'b0;
        drain();
        chk_flag("busy held until a rise", 1'b1, busy);
        send_exp(8'($urandom));
        chk_flag("busy after rise", 1'b0, busy);
        drain();
        rate = 3'($urandom % 5);
        drive = 1'b1;
        uid = $urandom;
        pulse_ctl(1'b1, 1'b0);
        host_u.hold_done(1'b1);
        pulse_ctl(1'b0, 1'b1);
        repeat (20) @(posedge clk);
        #1;
        chk_flag("user while wire held low", 1'b0, user_mode);
        host_u.hold_done(1'b0);
        wait_user();
        chk_flag("user after release", 1'b1, user_mode);
        chk_flag("completion driven", 1'b1, done_oe);
        chk_flag("completion high", 1'b1, done_o);
        read_id(1'b1, id_v);
        chk_word("user_identification option", uid, id_v);
        read_id(1'b0, id_v);
        chk_word("device id in user", DEVICE_ID_VALUE, id_v);
        prog_pulse(2);
        repeat (20) @(posedge clk);
        #1;
        chk_flag("user after short glitch", 1'b1, user_mode);
        host_u.send_byte(8'($urandom));
        repeat (6) @(posedge clk);
        #1;
        chk_flag("no byte without persist", 1'b0, out_valid);
        prog_pulse(3);
        for (int k = 0; k < 12 && mem_clear !== 1'b1; k++) @(posedge clk);
        #1;
        chk_flag("restart on 300 ns pulse", 1'b1, mem_clear);
        wait_load();
        pulse_ctl(1'b0, 1'b1);
        wait_user();
        chk_flag("open drain by default", 1'b0, done_oe);
        chk_flag("completion wire high", 1'b1, done_wire);
        read_id(1'b1, id_v);
        chk_word("user_identification default", USER_IDENTIFICATION_RESET, id_v);
        @(posedge clk);
        #1;
        prog_n = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        chk_flag("clear while held low", 1'b1, mem_clear);
        chk_flag("user left on request", 1'b0, user_mode);
        prog_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk_flag("clear continues after release", 1'b1, mem_clear);
        wait_load();
        persist = 1'b1;
        drive = 1'b0;
        pulse_ctl(1'b1, 1'b0);
        pulse_ctl(1'b0, 1'b1);
        wait_user();
        send_exp(8'($urandom));
        drain();
        chk_flag("all bytes seen", 1'b1, exp_q.size() == 0);
        // strap is followed while clearing, so a restart switches to master
        mstr = 1'b1;
        prog_pulse(3);
        repeat (6) @(posedge clk);
        wait_load();
        chk_flag("clock driven in master", 1'b1, clock_oe);
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: design/ccp_config_pins.sv */
// configuration control pins: clock, byte port, busy, program request, completion, id shift
//
// How it works
// - master modes: device drives config clock pin
// - data, select, direction sampled at clock rise
// - busy changes only after a clock rise
// - after completion, clock edges ignored unless persist
// - persist on: every edge may act again
// - oscillator rate selectable, default six megahertz; the code never applies RATE_DEFAULT and runs at RATE_POWER_ON until opt_load
// - slowest rate until rate option loaded
// - program request asynchronous, starts (re)configuration
// - low pulse resets logic, clears memory
// - held low: stall at memory clearing
// - low pulse of 300 ns restarts
// - power-up starts configuration without pulse
// - request high: finish, or stay user
// - completion output rises when process finishes
// - completion driven high or open-drain option
// - external low on completion delays start-up
// - fixed 32-bit device id readable by jtag
// - jtag port works before, during, after
// - user_identification set by option, default given
`default_nettype none
module ccp_config_pins
    import ccp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic master_mode,
    input wire logic cfg_clock_pin_i,
    output logic cfg_clock_pin_o,
    output logic cfg_clock_pin_oe,
    input wire logic [7:0] cfg_data_byte,
    input wire logic cfg_select_n,
    input wire logic cfg_read_write_n,
    output logic busy,
    input wire logic program_request_n,
    input wire logic completion_pin_i,
    output logic completion_pin_o,
    output logic completion_pin_oe,
    input wire logic jtag_tck,
    input wire logic jtag_tms,
    input wire logic jtag_tdi,
    input wire logic jtag_user_select,
    output logic jtag_tdo,
    output logic mem_clear,
    output logic user_mode,
    output logic [7:0] cfg_byte_data,
    output logic cfg_byte_valid,
    input wire logic cfg_byte_ready,
    input wire logic opt_load,
    input wire logic [2:0] osc_rate_option,
    input wire logic completion_drive_option,
    input wire logic persist_option,
    input wire logic [31:0] user_identification_option,
    input wire logic cfg_end
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYNC_W-1:0] pin_meta_q, pin_sync_q, pin_raw;
    logic [7:0] data_s;
    logic sel_n_s, rdwr_n_s, cfg_clock_pin_s, prog_s, done_s, tck_s, tms_s, tdi_s, master_s, usel_s;
    // data and strobes share the clock's delay so they line up at its edge
    assign pin_raw = {jtag_user_select, master_mode, jtag_tdi, jtag_tms, jtag_tck,
                      completion_pin_i, program_request_n, cfg_clock_pin_i,
                      cfg_read_write_n, cfg_select_n, cfg_data_byte};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_meta_q <= SYNC_RESET;
            pin_sync_q <= SYNC_RESET;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // field split mirrors the packing of pin_raw above
    assign {usel_s, master_s, tdi_s, tms_s, tck_s, done_s, prog_s, cfg_clock_pin_s, rdwr_n_s, sel_n_s,
            data_s} = pin_sync_q;

    // ****************************************
    // program request filter
    // ****************************************
    logic [2:0] prog_cnt_q, prog_cnt_d;
    logic restart;
    // pulses shorter than the minimum never reach the count limit
    assign prog_cnt_d = prog_s ? 3'h0 :
                        (prog_cnt_q == PROG_CNT_MAX) ? PROG_CNT_MAX : prog_cnt_q + 3'h1;
    assign restart = (prog_cnt_q == PROG_CNT_MAX);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prog_cnt_q <= 3'h0;
        end else begin
            prog_cnt_q <= prog_cnt_d;
        end
    end

    // ****************************************
    // sequence and options
    // ****************************************
    ccp_state_t state_q, state_d;
    logic [3:0] clear_cnt_q;
    logic [2:0] active_rate_q;
    logic drive_opt_q, persist_q, mode_q;
    logic [31:0] user_identification_q;
    always_comb begin
        state_d = state_q;
        case (state_q)
            CCP_ST_CLEAR: begin
                if (prog_s && clear_cnt_q == CLEAR_CYC) begin
                    state_d = CCP_ST_LOAD;
                end
            end
            CCP_ST_LOAD: begin
                if (cfg_end) begin
                    state_d = CCP_ST_RELEASE;
                end
            end
            CCP_ST_RELEASE: begin
                if (done_s) begin
                    state_d = CCP_ST_USER;
                end
            end
            CCP_ST_USER: begin
                state_d = CCP_ST_USER;
            end
            default: begin
                state_d = CCP_ST_CLEAR;
            end
        endcase
        if (restart) begin
            state_d = CCP_ST_CLEAR;
        end
    end

    // reset lands in clearing, so power-up configures by itself
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= CCP_ST_CLEAR;
        end else begin
            state_q <= state_d;
        end
    end

    // clearing count only runs while the request is released
    always_ff @(posedge clk) begin
        if (!reset_n || state_q != CCP_ST_CLEAR || !prog_s) begin
            clear_cnt_q <= 4'h0;
        end else if (clear_cnt_q != CLEAR_CYC) begin
            clear_cnt_q <= clear_cnt_q + 4'h1;
        end
    end

    // options loaded from the data; clearing restores defaults
    always_ff @(posedge clk) begin
        if (!reset_n || state_q == CCP_ST_CLEAR) begin
            active_rate_q <= RATE_POWER_ON;
            drive_opt_q <= 1'b0;
            persist_q <= 1'b0;
            user_identification_q <= USER_IDENTIFICATION_RESET;
        end else if (opt_load) begin
            active_rate_q <= osc_rate_option;
            drive_opt_q <= completion_drive_option;
            persist_q <= persist_option;
            user_identification_q <= user_identification_option;
        end
    end

    // mode strap followed while clearing, when the sync flops have long settled
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_q <= 1'b0;
        end else if (state_q == CCP_ST_CLEAR) begin
            mode_q <= master_s;
        end
    end

    // ****************************************
    // internal oscillator for master modes
    // ****************************************
    logic [4:0] half_cyc, div_cnt_q;
    logic osc_q, osc_run, osc_flip;
    // half period of the active rate
    assign half_cyc = (active_rate_q == RATE_50M) ? HALF_50M :
                      (active_rate_q == RATE_25M) ? HALF_25M :
                      (active_rate_q == RATE_12M) ? HALF_12M :
                      (active_rate_q == RATE_6M) ? HALF_6M : HALF_3M;
    assign osc_run = mode_q & ((state_q != CCP_ST_USER) | persist_q);
    assign osc_flip = osc_run & (div_cnt_q >= half_cyc - 5'h01);

    always_ff @(posedge clk) begin
        if (!reset_n || !osc_run) begin
            div_cnt_q <= 5'h00;
            osc_q <= 1'b0;
        end else begin
            div_cnt_q <= osc_flip ? 5'h00 : div_cnt_q + 5'h01;
            osc_q <= osc_q ^ osc_flip;
        end
    end

    // ****************************************
    // byte port
    // ****************************************
    logic cfg_clock_pin_prev_q, cfg_rise, port_live, buf_push, buf_in_ready, busy_q, cfg_clock_pin_oe_q;
    // slave edges from the pin, master edges from our oscillator
    assign cfg_rise = mode_q ? (osc_flip & !osc_q) : (cfg_clock_pin_s & !cfg_clock_pin_prev_q);
    // port only listens after completion when persist is set
    assign port_live = (state_q == CCP_ST_LOAD) | ((state_q == CCP_ST_USER) & persist_q);
    // write byte taken at the rise when selected; reads are not served
    assign buf_push = cfg_rise & port_live & !sel_n_s & !rdwr_n_s;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_clock_pin_prev_q <= 1'b1;
            busy_q <= 1'b0;
            cfg_clock_pin_oe_q <= 1'b0;
        end else begin
            cfg_clock_pin_prev_q <= cfg_clock_pin_s;
            // busy only moves on a rise, showing a full buffer
            busy_q <= cfg_rise ? !buf_in_ready : busy_q;
            // drive the clock pin in master modes
            cfg_clock_pin_oe_q <= osc_run;
        end
    end

    // a stall by the memory writer backs up into busy; the byte sampled at the rise that raises busy is dropped
    ccp_pair_buf #(
        .WIDTH(BYTE_W)
    ) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(data_s),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .out_data(cfg_byte_data),
        .out_valid(cfg_byte_valid),
        .out_ready(cfg_byte_ready)
    );

    // ****************************************
    // completion pin
    // ****************************************
    logic done_flag, done_o_q, done_oe_q;
    assign done_flag = (state_q == CCP_ST_RELEASE) | (state_q == CCP_ST_USER);
    // low until finished, then driven high or released
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_o_q <= 1'b0;
            done_oe_q <= 1'b1;
        end else begin
            done_o_q <= done_flag & drive_opt_q;
            done_oe_q <= !done_flag | drive_opt_q;
        end
    end

    // ****************************************
    // id shift port
    // ****************************************
    logic tck_prev_q, tck_rise, tck_fall, tdo_q;
    logic [31:0] id_shift_q;
    assign tck_rise = tck_s & !tck_prev_q;
    assign tck_fall = !tck_s & tck_prev_q;

    // capture on tms high, shift lsb first otherwise; never gated by state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tck_prev_q <= 1'b0;
            id_shift_q <= DEVICE_ID_VALUE;
            tdo_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
            if (tck_rise) begin
                id_shift_q <= tms_s ? (usel_s ? user_identification_q : DEVICE_ID_VALUE)
                                    : {tdi_s, id_shift_q[31:1]};
            end
            if (tck_fall) begin
                tdo_q <= id_shift_q[0];
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cfg_clock_pin_o = osc_q;
    assign cfg_clock_pin_oe = cfg_clock_pin_oe_q;
    assign busy = busy_q;
    assign completion_pin_o = done_o_q;
    assign completion_pin_oe = done_oe_q;
    assign jtag_tdo = tdo_q;
    assign mem_clear = (state_q == CCP_ST_CLEAR);
    assign user_mode = (state_q == CCP_ST_USER);

    // ****************************************
    // checks
    // ****************************************
    AST_MASTER_DRIVES: assert property (@(posedge clk) disable iff (!reset_n)
        osc_run |=> cfg_clock_pin_oe) else $error("clock pin not driven in master mode");
    AST_BUSY_ON_RISE: assert property (@(posedge clk) disable iff (!reset_n)
        !cfg_rise |=> $stable(busy)) else $error("busy moved without a clock rise");
    AST_IGNORE_AFTER: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_USER && !persist_q && !cfg_byte_valid) |=> !cfg_byte_valid)
        else $error("byte taken after end");
    AST_PERSIST_TAKES: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_USER && persist_q && cfg_rise && !sel_n_s && !rdwr_n_s
         && buf_in_ready) |=> cfg_byte_valid) else $error("persist byte not taken");
    AST_SLOW_START: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == CCP_ST_CLEAR |=> active_rate_q == RATE_POWER_ON) else $error("rate not slowest");
    AST_HOLD_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_CLEAR && !prog_s) |=> state_q == CCP_ST_CLEAR)
        else $error("left clearing while request low");
    AST_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
        (!prog_s)[*4] |=> state_q == CCP_ST_CLEAR) else $error("long low pulse did not restart");
    AST_USER_STAYS: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_USER && prog_cnt_q != PROG_CNT_MAX) |=> user_mode)
        else $error("left user mode without restart");
    AST_DONE_LOW: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_LOAD)[*2] |-> completion_pin_oe && !completion_pin_o)
        else $error("completion not low while loading");
    AST_WAIT_RELEASE: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == CCP_ST_RELEASE && !done_s && !restart) |=> !user_mode)
        else $error("start-up while completion held low");
    AST_DEVICE_ID: assert property (@(posedge clk) disable iff (!reset_n)
        (tck_rise && tms_s && !usel_s) |=> id_shift_q == DEVICE_ID_VALUE)
        else $error("device id not captured");
    COV_USER: cover property (@(posedge clk) disable iff (!reset_n) $rose(user_mode));
    COV_RESTART: cover property (@(posedge clk) disable iff (!reset_n) user_mode ##1 mem_clear);
    COV_PERSIST: cover property (@(posedge clk) disable iff (!reset_n) user_mode && buf_push);
    COV_BUSY: cover property (@(posedge clk) disable iff (!reset_n) $rose(busy));

endmodule
`default_nettype wire

/* File: design/ccp_pair_buf.sv */
// two-entry buffer between the pin sampler and the configuration memory writer
`default_nettype none
module ccp_pair_buf
    import ccp_pkg::*;
#(
    parameter int WIDTH = BYTE_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    logic [WIDTH-1:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_q];

    // entry storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wr_q <= wr_q ^ push;
            rd_q <= rd_q ^ pop;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule
`default_nettype wire

/* File: design/ccp_pkg.sv */
// constants and types shared by the configuration control pin logic
`default_nettype none
package ccp_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int PROG_MIN_LOW_NS = 300;
    // least time, so round up to whole clock cycles
    localparam int PROG_MIN_LOW_CYC = (PROG_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] PROG_CNT_MAX = 3'(PROG_MIN_LOW_CYC);
    // cycles spent wiping configuration memory once the request is released
    localparam logic [3:0] CLEAR_CYC = 4'h8;

    // ****************************************
    // widths
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int ID_W = 32;
    localparam int SYNC_W = 18;
    // idle levels: select, direction, clock, request and completion high
    localparam logic [17:0] SYNC_RESET = 18'h01F00;

    // ****************************************
    // identification values
    // ****************************************
    // arbitrary value, not the code of any real part; bit 0 set as a jtag id requires
    localparam logic [31:0] DEVICE_ID_VALUE = 32'h0A5C_3001;
    localparam logic [31:0] USER_IDENTIFICATION_RESET = 32'h0FFF_FFFF;

    // ****************************************
    // oscillator rate codes and half periods in clk cycles
    // ****************************************
    localparam logic [2:0] RATE_3M = 3'h0;
    localparam logic [2:0] RATE_6M = 3'h1;
    localparam logic [2:0] RATE_12M = 3'h2;
    localparam logic [2:0] RATE_25M = 3'h3;
    localparam logic [2:0] RATE_50M = 3'h4;
    localparam logic [2:0] RATE_DEFAULT = RATE_6M;
    localparam logic [2:0] RATE_POWER_ON = RATE_3M;
    localparam logic [4:0] HALF_3M = 5'h10;
    localparam logic [4:0] HALF_6M = 5'h08;
    localparam logic [4:0] HALF_12M = 5'h04;
    localparam logic [4:0] HALF_25M = 5'h02;
    localparam logic [4:0] HALF_50M = 5'h01;

    // ****************************************
    // configuration sequence
    // ****************************************
    typedef enum logic [1:0] {
        CCP_ST_CLEAR = 2'h0,
        CCP_ST_LOAD = 2'h1,
        CCP_ST_RELEASE = 2'h2,
        CCP_ST_USER = 2'h3
    } ccp_state_t;

endpackage
`default_nettype wire
